/* File: mbm_pkg.sv */
// Shared constants of the battery monitor two-wire register slave.
// Assumes a single 200 MHz clock; all other rates are derived from it.
package mbm_pkg;
    // Register byte addresses.
    localparam logic [7:0] ADDR_STATUS_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_TEMPERATURE_HIGH = 8'h0a;
    localparam logic [7:0] ADDR_TEMPERATURE_LOW = 8'h0b;
    localparam logic [7:0] ADDR_VOLTAGE_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_VOLTAGE_LOW = 8'h0d;
    localparam logic [7:0] ADDR_CURRENT_HIGH = 8'h0e;
    localparam logic [7:0] ADDR_CURRENT_LOW = 8'h0f;
    localparam logic [7:0] ADDR_CHARGE_ACCUM_HIGH = 8'h10;
    localparam logic [7:0] ADDR_CHARGE_ACCUM_LOW = 8'h11;
    localparam logic [7:0] ADDR_CURRENT_OFFSET_BIAS = 8'h61;
    localparam logic [7:0] ADDR_ACCUMULATION_BIAS = 8'h62;

    // Status/config field positions.
    localparam int STAT_RESERVED_BIT = 7;
    localparam int STAT_POWER_UP_BIT = 6;
    localparam int STAT_SLEEP_ALLOW_BIT = 5;
    localparam int STAT_NEG_BLANK_BIT = 4;
    localparam int STAT_GIO_BIT = 3;

    // Reset values and fixed constants.
    localparam logic [7:0] STATUS_CONFIG_RESET = 8'hc0;
    localparam logic [7:0] BIAS_RESET = 8'h00;
    localparam logic [2:0] ADDRESS_LOW_RESET = 3'h0;
    localparam logic [3:0] SLAVE_ADDR_HIGH = 4'h9;
    localparam logic [7:0] PAST_END_DATA = 8'hff;
    localparam logic [7:0] RESERVED_DATA = 8'h00;

    // Timing: both lines low this long lets the part sleep.
    localparam longint CLK_HZ = 200000000;
    localparam longint SLEEP_TIME_S = 2;
    localparam longint SLEEP_CYCLES = SLEEP_TIME_S * CLK_HZ;

    // Blanking thresholds in microvolts; one current step is 15625/10000 uV.
    localparam int CHARGE_BLANK_UV = 100;
    localparam int DISCHARGE_BLANK_UV = 25;
    localparam int CHARGE_BLANK_LSB = (CHARGE_BLANK_UV * 10000) / 15625;
    localparam int DISCHARGE_BLANK_LSB = (DISCHARGE_BLANK_UV * 10000) / 15625;

    // Two-wire slave states.
    typedef enum logic [3:0] {
        MBM_IDLE, MBM_ADDR, MBM_ADDR_ACK, MBM_MADDR, MBM_MADDR_ACK,
        MBM_WDATA, MBM_WDATA_ACK, MBM_RDATA, MBM_RACK
    } mbm_state_t;
endpackage

/* File: mbm_accum.sv */
// Charge accumulator: adds current plus bias to a clamped running count.
// Assumes step, current and control come from logic on the same clock.
`timescale 1ns/1ps
module mbm_accum import mbm_pkg::*; #(
    parameter int FRAC_W = 8
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Accumulation inputs.
    input wire logic step,
    input wire logic [15:0] current,
    input wire logic [7:0] bias,
    input wire logic neg_blank,
    // Host writes.
    input wire logic wr_high,
    input wire logic wr_low,
    input wire logic [7:0] wdata,
    // Result.
    output logic [15:0] charge_accumulator
);
    localparam int W = 16 + FRAC_W;

    logic [W-1:0] acc_r;
    logic [W-1:0] acc_nxt;
    logic signed [W+1:0] term;
    logic signed [W+1:0] sum;
    logic signed [16:0] cur_eff;

    always_comb begin
        cur_eff = 17'(signed'(current));
        // Charge blanking always; discharge blanking only when enabled.
        if (!current[15] && cur_eff < 17'(CHARGE_BLANK_LSB)) begin
            cur_eff = '0; // R12
        end else if (current[15] && neg_blank && cur_eff >= -17'(DISCHARGE_BLANK_LSB)) begin
            cur_eff = '0; // R12
        end
        // The bias term is added after blanking so it is never suppressed.
        term = (W+2)'(cur_eff) + (W+2)'(signed'(bias)); // R2 R3
        sum = signed'({2'b00, acc_r}) + term; // R1
        acc_nxt = acc_r;
        if (wr_high) begin
            acc_nxt = {wdata, acc_r[W-9 -: 8], {FRAC_W{1'b0}}};
        end else if (wr_low) begin
            acc_nxt = {acc_r[W-1 -: 8], wdata, {FRAC_W{1'b0}}};
        end else if (step) begin
            if (sum < 0) begin
                acc_nxt = '0;
            end else if (sum[W]) begin
                acc_nxt = {16'hffff, {FRAC_W{1'b0}}};
            end else begin
                acc_nxt = sum[W-1:0];
            end
        end
    end

    // The count survives reset on purpose, so this register has none.
    always_ff @(posedge ref_clk) begin
        acc_r <= acc_nxt; // R7
    end

    assign charge_accumulator = acc_r[W-1 -: 16];
endmodule

/* File: mbm_i2c_slave.sv */
// Overview of operation
// R1: New accumulator equals current plus accumulation bias plus previous accumulator.
// R2: Bias term is added even when the current sample is blanked.
// R3: Bias is a signed step value applied to every later accumulation.
// R4: Host must program the bias after every power-up.
// R5: Reading a pair's high byte latches both bytes for the command.
// R6: Host should read both bytes of a pair in one command.
// R7: Measurement pairs are read-only; accumulator pair is writable and survives reset.
// R8: Offset and accumulation bias registers are writable and reset to zero.
// R9: Status/config register is mixed access, reset value 11000000b.
// R10: Power-up flag sets at reset and clears only by host writing zero.
// R11: Sleep-allow enables sleep after both lines stay low two seconds.
// R12: Negative-blank-enable blanks small discharge results from accumulation.
// R13: General I/O bit drives the open-drain pin; reads return the pin level.
// R14: Address-low bits set the slave address low bits; default 1001000b.
// R15: Device is only a slave; the master makes clock, START and STOP.
// R16: Data line is input while receiving and open-drain when returning data.
// R17: One bit per clock; data changing while clock high is START or STOP.
// R18: Device detects START and STOP made by the master.
// R19: Repeated START is accepted in place of STOP then START.
// R20: Acknowledge pulls data low across the ninth clock pulse.
// R21: Master retries after a missing acknowledge.
// R22: Bytes go most significant bit first; pairs high byte at even address.
// R23: Byte address increments after the last bit of each byte.
// R24: Writes to read-only, reserved or past-end addresses and partial bytes are dropped.
// R25: Direction bit zero means write, one means read.
// R26: After STOP or address mismatch, release the line and await START.
//
// Two-wire register slave of a battery monitor, holding status and bias registers.
// Assumes the serial lines and the I/O pin are asynchronous; measurement
// inputs and the accumulation step come from logic on ref_clk.
`timescale 1ns/1ps
module mbm_i2c_slave import mbm_pkg::*; #(
    parameter longint SLEEP_COUNT = SLEEP_CYCLES,
    parameter int FRAC_W = 8
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Two-wire bus pins.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // General I/O open-drain pin.
    input wire logic gio_in,
    output logic gio_out,
    output logic gio_oe,
    // Measurement results and accumulation step.
    input wire logic [15:0] temperature,
    input wire logic [15:0] voltage,
    input wire logic [15:0] current,
    input wire logic accum_step,
    // Controls toward the measurement logic.
    output logic [7:0] current_offset_bias,
    output logic negative_blank_enable,
    output logic sleep_req
);
    // Synchronisers and edge detection.
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic [1:0] gio_sync_r;
    logic scl_prev_r;
    logic sda_prev_r;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // Slave state.
    mbm_state_t state_r, state_nxt;
    logic [3:0] bitcnt_r, bitcnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [8:0] ptr_r, ptr_nxt;
    logic [8:0] wr_addr_r, wr_addr_nxt;
    logic rw_r, rw_nxt;
    logic sda_oe_r, sda_oe_nxt;
    logic latch_vld_r, latch_vld_nxt;
    logic [7:0] latch_base_r, latch_base_nxt;
    logic [7:0] latch_low_r, latch_low_nxt;

    // Registers.
    logic power_up_flag_r, power_up_flag_nxt;
    logic sleep_allow_r, sleep_allow_nxt;
    logic neg_blank_r, neg_blank_nxt;
    logic gio_pull_r, gio_pull_nxt;
    logic [2:0] address_low_bits_r, address_low_bits_nxt;
    logic [7:0] offset_bias_r, offset_bias_nxt;
    logic [7:0] accum_bias_r, accum_bias_nxt;
    logic wr_acc_high;
    logic wr_acc_low;
    logic [15:0] charge_accumulator;

    // Sleep detection.
    logic [31:0] idle_cnt_r, idle_cnt_nxt;
    logic sleep_r, sleep_nxt;

    logic [7:0] rd_data;
    logic [15:0] pair_val;
    logic wr_en;

    // Returns the 16-bit pair whose high byte sits at the given even address.
    function automatic logic [15:0] pair_of(input logic [7:0] a);
        case (a)
            ADDR_TEMPERATURE_HIGH: pair_of = temperature;
            ADDR_VOLTAGE_HIGH: pair_of = voltage;
            ADDR_CURRENT_HIGH: pair_of = current;
            ADDR_CHARGE_ACCUM_HIGH: pair_of = charge_accumulator;
            default: pair_of = 16'h0000;
        endcase
    endfunction

    // Returns true when the address is the high byte of a two-byte register.
    function automatic logic is_pair_high(input logic [7:0] a);
        is_pair_high = (a == ADDR_TEMPERATURE_HIGH) || (a == ADDR_VOLTAGE_HIGH) ||
            (a == ADDR_CURRENT_HIGH) || (a == ADDR_CHARGE_ACCUM_HIGH);
    endfunction

    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];
    assign scl_rise = scl_s && !scl_prev_r;
    assign scl_fall = !scl_s && scl_prev_r;
    assign start_det = scl_s && scl_prev_r && sda_prev_r && !sda_s; // R18
    assign stop_det = scl_s && scl_prev_r && !sda_prev_r && sda_s; // R18

    // Read data for the byte at the pointer.
    always_comb begin
        pair_val = pair_of({ptr_r[7:1], 1'b0});
        rd_data = RESERVED_DATA;
        if (ptr_r[8]) begin
            rd_data = PAST_END_DATA;
        end else if (is_pair_high(ptr_r[7:0])) begin
            rd_data = pair_val[15:8]; // R22
        end else if (is_pair_high({ptr_r[7:1], 1'b0}) && ptr_r[0]) begin
            // The latched copy wins so the pair stays coherent.
            if (latch_vld_r && latch_base_r == {ptr_r[7:1], 1'b0}) begin
                rd_data = latch_low_r; // R5
            end else begin
                rd_data = pair_val[7:0];
            end
        end else begin
            case (ptr_r[7:0])
                ADDR_STATUS_CONFIG: rd_data = {1'b1, power_up_flag_r, sleep_allow_r,
                    neg_blank_r, gio_sync_r[1], address_low_bits_r}; // R13
                ADDR_CURRENT_OFFSET_BIAS: rd_data = offset_bias_r;
                ADDR_ACCUMULATION_BIAS: rd_data = accum_bias_r;
                default: rd_data = RESERVED_DATA;
            endcase
        end
    end

    // Protocol engine; the slave never drives the clock.
    always_comb begin
        state_nxt = state_r; // R15
        bitcnt_nxt = bitcnt_r;
        shift_nxt = shift_r;
        ptr_nxt = ptr_r;
        wr_addr_nxt = wr_addr_r;
        rw_nxt = rw_r;
        sda_oe_nxt = sda_oe_r;
        latch_vld_nxt = latch_vld_r;
        latch_base_nxt = latch_base_r;
        latch_low_nxt = latch_low_r;
        wr_en = 1'b0;
        if (start_det) begin
            state_nxt = MBM_ADDR; // R19
            bitcnt_nxt = '0;
            sda_oe_nxt = 1'b0;
            latch_vld_nxt = 1'b0;
        end else if (stop_det) begin
            state_nxt = MBM_IDLE; // R26
            sda_oe_nxt = 1'b0;
            latch_vld_nxt = 1'b0;
        end else if (scl_rise) begin
            case (state_r)
                MBM_ADDR, MBM_MADDR, MBM_WDATA: begin
                    shift_nxt = {shift_r[6:0], sda_s}; // R17 R22
                    bitcnt_nxt = bitcnt_r + 4'h1;
                end
                MBM_RDATA: bitcnt_nxt = bitcnt_r + 4'h1;
                MBM_RACK: begin
                    // A not-acknowledge from the master ends the read.
                    if (sda_s) begin
                        state_nxt = MBM_IDLE; // R20
                    end
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state_r)
                MBM_ADDR: begin
                    if (bitcnt_r == 4'h8) begin
                        if (shift_r[7:1] == {SLAVE_ADDR_HIGH, address_low_bits_r}) begin // R14
                            state_nxt = MBM_ADDR_ACK;
                            rw_nxt = shift_r[0]; // R25
                            sda_oe_nxt = 1'b1; // R20
                        end else begin
                            state_nxt = MBM_IDLE; // R26
                        end
                    end
                end
                MBM_ADDR_ACK: begin
                    bitcnt_nxt = '0;
                    if (rw_r) begin
                        state_nxt = MBM_RDATA;
                        shift_nxt = rd_data;
                        sda_oe_nxt = !rd_data[7]; // R16
                        if (!ptr_r[8] && is_pair_high(ptr_r[7:0])) begin
                            latch_vld_nxt = 1'b1; // R5
                            latch_base_nxt = ptr_r[7:0];
                            latch_low_nxt = pair_val[7:0];
                        end
                    end else begin
                        state_nxt = MBM_MADDR;
                        sda_oe_nxt = 1'b0; // R16
                    end
                end
                MBM_MADDR: begin
                    if (bitcnt_r == 4'h8) begin
                        ptr_nxt = {1'b0, shift_r};
                        state_nxt = MBM_MADDR_ACK;
                        sda_oe_nxt = 1'b1; // R20
                    end
                end
                MBM_WDATA: begin
                    if (bitcnt_r == 4'h8) begin
                        wr_addr_nxt = ptr_r;
                        ptr_nxt = ptr_r[8] ? ptr_r : ptr_r + 9'h001; // R23
                        state_nxt = MBM_WDATA_ACK;
                        sda_oe_nxt = 1'b1; // R20
                    end
                end
                MBM_MADDR_ACK, MBM_WDATA_ACK: begin
                    // A byte is stored only once its acknowledge completes.
                    wr_en = (state_r == MBM_WDATA_ACK); // R24
                    state_nxt = MBM_WDATA;
                    bitcnt_nxt = '0;
                    sda_oe_nxt = 1'b0;
                end
                MBM_RDATA: begin
                    if (bitcnt_r == 4'h8) begin
                        ptr_nxt = ptr_r[8] ? ptr_r : ptr_r + 9'h001; // R23
                        state_nxt = MBM_RACK;
                        sda_oe_nxt = 1'b0;
                    end else begin
                        shift_nxt = {shift_r[6:0], 1'b1};
                        sda_oe_nxt = !shift_r[6]; // R16 R22
                    end
                end
                MBM_RACK: begin
                    state_nxt = MBM_RDATA;
                    bitcnt_nxt = '0;
                    shift_nxt = rd_data;
                    sda_oe_nxt = !rd_data[7];
                    if (!ptr_r[8] && is_pair_high(ptr_r[7:0])) begin
                        latch_vld_nxt = 1'b1; // R5
                        latch_base_nxt = ptr_r[7:0];
                        latch_low_nxt = pair_val[7:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Register writes from completed bytes.
    always_comb begin
        power_up_flag_nxt = power_up_flag_r;
        sleep_allow_nxt = sleep_allow_r;
        neg_blank_nxt = neg_blank_r;
        gio_pull_nxt = gio_pull_r;
        address_low_bits_nxt = address_low_bits_r;
        offset_bias_nxt = offset_bias_r;
        accum_bias_nxt = accum_bias_r;
        wr_acc_high = 1'b0;
        wr_acc_low = 1'b0;
        if (wr_en && !wr_addr_r[8]) begin // R24
            case (wr_addr_r[7:0])
                ADDR_STATUS_CONFIG: begin
                    power_up_flag_nxt = power_up_flag_r & shift_r[STAT_POWER_UP_BIT]; // R10
                    sleep_allow_nxt = shift_r[STAT_SLEEP_ALLOW_BIT]; // R11
                    neg_blank_nxt = shift_r[STAT_NEG_BLANK_BIT]; // R12
                    gio_pull_nxt = !shift_r[STAT_GIO_BIT]; // R13
                    address_low_bits_nxt = shift_r[2:0]; // R14
                end
                ADDR_CHARGE_ACCUM_HIGH: wr_acc_high = 1'b1; // R7
                ADDR_CHARGE_ACCUM_LOW: wr_acc_low = 1'b1; // R7
                ADDR_CURRENT_OFFSET_BIAS: offset_bias_nxt = shift_r; // R8
                ADDR_ACCUMULATION_BIAS: accum_bias_nxt = shift_r; // R8 R3
                default: ;
            endcase
        end
    end

    // Sleep timer: both lines low for the full count.
    always_comb begin
        idle_cnt_nxt = idle_cnt_r;
        sleep_nxt = 1'b0;
        if (!sleep_allow_r || scl_s || sda_s) begin
            idle_cnt_nxt = '0;
        end else if (64'(idle_cnt_r) < SLEEP_COUNT) begin
            idle_cnt_nxt = idle_cnt_r + 32'h1;
        end else begin
            sleep_nxt = 1'b1; // R11
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            gio_sync_r <= 2'h0;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
            state_r <= MBM_IDLE;
            bitcnt_r <= '0;
            shift_r <= '0;
            ptr_r <= '0;
            wr_addr_r <= '0;
            rw_r <= 1'b0;
            sda_oe_r <= 1'b0;
            latch_vld_r <= 1'b0;
            latch_base_r <= '0;
            latch_low_r <= '0;
            power_up_flag_r <= STATUS_CONFIG_RESET[STAT_POWER_UP_BIT]; // R9 R10
            sleep_allow_r <= STATUS_CONFIG_RESET[STAT_SLEEP_ALLOW_BIT];
            neg_blank_r <= STATUS_CONFIG_RESET[STAT_NEG_BLANK_BIT];
            gio_pull_r <= !STATUS_CONFIG_RESET[STAT_GIO_BIT];
            address_low_bits_r <= ADDRESS_LOW_RESET;
            offset_bias_r <= BIAS_RESET; // R8
            accum_bias_r <= BIAS_RESET; // R8
            idle_cnt_r <= '0;
            sleep_r <= 1'b0;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            gio_sync_r <= {gio_sync_r[0], gio_in};
            scl_prev_r <= scl_s;
            sda_prev_r <= sda_s;
            state_r <= state_nxt;
            bitcnt_r <= bitcnt_nxt;
            shift_r <= shift_nxt;
            ptr_r <= ptr_nxt;
            wr_addr_r <= wr_addr_nxt;
            rw_r <= rw_nxt;
            sda_oe_r <= sda_oe_nxt;
            latch_vld_r <= latch_vld_nxt;
            latch_base_r <= latch_base_nxt;
            latch_low_r <= latch_low_nxt;
            power_up_flag_r <= power_up_flag_nxt;
            sleep_allow_r <= sleep_allow_nxt;
            neg_blank_r <= neg_blank_nxt;
            gio_pull_r <= gio_pull_nxt;
            address_low_bits_r <= address_low_bits_nxt;
            offset_bias_r <= offset_bias_nxt;
            accum_bias_r <= accum_bias_nxt;
            idle_cnt_r <= idle_cnt_nxt;
            sleep_r <= sleep_nxt;
        end
    end

    mbm_accum #(
        .FRAC_W(FRAC_W)
    ) u_accum (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .step(accum_step),
        .current(current),
        .bias(accum_bias_r),
        .neg_blank(neg_blank_r),
        .wr_high(wr_acc_high),
        .wr_low(wr_acc_low),
        .wdata(shift_r),
        .charge_accumulator(charge_accumulator)
    );

    // Open-drain outputs only ever pull low.
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_r;
    assign gio_out = 1'b0;
    assign gio_oe = gio_pull_r; // R13
    assign current_offset_bias = offset_bias_r;
    assign negative_blank_enable = neg_blank_r;
    assign sleep_req = sleep_r;
endmodule

/* File: mbm_i2c_slave_checker.sv */
// Pin-level checker for the two-wire register slave.
// Assumes it is bound to the slave and sees only its ports.
`timescale 1ns/1ps
module mbm_i2c_slave_checker import mbm_pkg::*; #(
    parameter longint SLEEP_COUNT = SLEEP_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Bus and I/O pins.
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic gio_out,
    input wire logic gio_oe,
    // Controls.
    input wire logic [7:0] current_offset_bias,
    input wire logic negative_blank_enable,
    input wire logic sleep_req
);
    longint low_cnt_r;
    longint low_cnt_nxt;
    // Cycles with both pins low; the slave's own count lags it.
    always_comb begin
        low_cnt_nxt = (scl_in || sda_in) ? 64'h0 : low_cnt_r + 64'h1;
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_r <= 64'h0;
        end else begin
            low_cnt_r <= low_cnt_nxt;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    AST_SDA_OPEN_DRAIN: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    AST_GIO_OPEN_DRAIN: assert property (gio_out == 1'b0)
        else $error("io pin driven high");
    AST_RESET_PINS: assert property ($rose(rstn) |-> !sda_oe && gio_oe)
        else $error("pins wrong after reset");
    AST_OE_RISE_LOW: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data pulled while clock high");
    AST_OE_FALL_LOW: assert property ($fell(sda_oe) |-> !scl_in)
        else $error("data released while clock high");
    AST_BIAS_AFTER_ACK: assert property ($changed(current_offset_bias) |->
        !scl_in && $past(scl_in, 2) == 1'b0)
        else $error("bias changed outside ack");
    AST_BLANK_AFTER_ACK: assert property ($changed(negative_blank_enable) |-> !scl_in)
        else $error("blank enable changed outside ack");
    AST_GIO_AFTER_ACK: assert property ($changed(gio_oe) |-> !scl_in)
        else $error("io enable changed outside ack");
    AST_SLEEP_AFTER_LOW: assert property ($rose(sleep_req) |-> low_cnt_r >= SLEEP_COUNT)
        else $error("sleep requested too early");
    AST_WAKE_ON_CLOCK: assert property (scl_in [*8] |-> !sleep_req)
        else $error("sleep held with clock high");
endmodule

bind mbm_i2c_slave mbm_i2c_slave_checker #(.SLEEP_COUNT(SLEEP_COUNT)) u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .gio_out(gio_out), .gio_oe(gio_oe),
    .current_offset_bias(current_offset_bias),
    .negative_blank_enable(negative_blank_enable), .sleep_req(sleep_req));

/* File: mbm_master.sv */
// Behavioural two-wire bus master facing the register slave.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module mbm_master (
    // Clock.
    input wire logic ref_clk,
    // Bus.
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Data moves mid-phase so it never races a clock edge.
    task automatic step(input logic c, input logic dl);
        @(posedge ref_clk);
        scl <= c;
        repeat (4) @(posedge ref_clk);
        sda_low <= dl;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic start();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                        output logic sack);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, !d[i]);
            step(1'b1, !d[i]);
            q[i] = sda;
        end
        step(1'b0, mack);
        step(1'b1, mack);
        sack = !sda;
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] a, d0, d1, output logic ok);
        logic [7:0] q;
        logic k;
        start();
        xfer({dev, 1'b0}, 1'b0, q, ok);
        xfer(a, 1'b0, q, k);
        xfer(d0, 1'b0, q, k);
        xfer(d1, 1'b0, q, k);
        stop();
    endtask
    task automatic rd(input logic [6:0] dev, input logic [7:0] a, output logic [15:0] v,
                      output logic ok);
        logic [7:0] q;
        logic k;
        start();
        xfer({dev, 1'b0}, 1'b0, q, ok);
        xfer(a, 1'b0, q, k);
        start();
        xfer({dev, 1'b1}, 1'b0, q, k);
        xfer(8'hff, 1'b1, v[15:8], k);
        xfer(8'hff, 1'b0, v[7:0], k);
        stop();
    endtask
endmodule

/* File: mbm_i2c_slave_test.sv */
// Self-checking bench of the two-wire register slave.
// Assumes pull-ups on the data and I/O lines and the bus master model.
`timescale 1ns/1ps
module mbm_i2c_slave_test;
    localparam logic [6:0] DEV = 7'h48;
    localparam logic [6:0] DEV_NEW = 7'h4b;
    logic ref_clk, rstn, scl, sda_low, sda_oe, gio_oe, accum_step;
    logic [15:0] temperature, voltage, current;
    logic [7:0] current_offset_bias;
    logic negative_blank_enable, sleep_req;
    logic [15:0] v;
    logic ok;
    int miscompares, comparisons;
    wire sda;
    assign sda = !(sda_low || sda_oe);
    initial ref_clk = 1'b0;
    always #2.5 ref_clk = !ref_clk;
    mbm_i2c_slave #(.SLEEP_COUNT(100)) u_dut (
        .ref_clk(ref_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(),
        .sda_oe(sda_oe), .gio_in(!gio_oe), .gio_out(), .gio_oe(gio_oe),
        .temperature(temperature), .voltage(voltage), .current(current),
        .accum_step(accum_step), .current_offset_bias(current_offset_bias),
        .negative_blank_enable(negative_blank_enable), .sleep_req(sleep_req));
    mbm_master u_master (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
    initial begin
        rstn = 1'b0;
        temperature = 16'h1234;
        voltage = 16'h0c0d;
        current = 16'h0000;
        accum_step = 1'b0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        u_master.rd(DEV, 8'h01, v, ok);
        check(v[15:8], 8'hc0);
        check(gio_oe, 1'b1);
        u_master.rd(DEV, 8'h61, v, ok);
        check(v[15:8], 8'h00);
        check(v[7:0], 8'h00);
        $display("done: reset values");
        u_master.wr(DEV, 8'h61, 8'h80, 8'h7f, ok);
        check(current_offset_bias, 8'h80);
        u_master.wr(DEV, 8'h10, 8'h00, 8'h00, ok);
        repeat (3) begin
            @(posedge ref_clk);
            accum_step <= 1'b1;
            @(posedge ref_clk);
            accum_step <= 1'b0;
        end
        u_master.rd(DEV, 8'h10, v, ok);
        check(v[15:8], 8'h00);
        check(v[7:0], 8'h01);
        $display("done: accumulation");
        u_master.wr(DEV, 8'h01, 8'h18, 8'h5a, ok);
        u_master.rd(DEV, 8'h01, v, ok);
        check(v[15:8], 8'h98);
        check(v[7:0], 8'h00);
        check(negative_blank_enable, 1'b1);
        check(gio_oe, 1'b0);
        $display("done: status fields");
        u_master.wr(DEV, 8'h01, 8'h43, 8'h00, ok);
        u_master.rd(DEV, 8'h01, v, ok);
        check(ok, 1'b0);
        u_master.rd(DEV_NEW, 8'h01, v, ok);
        check(ok, 1'b1);
        check(v[15:8], 8'h83);
        $display("done: slave address");
        u_master.wr(DEV_NEW, 8'h0a, 8'h55, 8'h66, ok);
        u_master.rd(DEV_NEW, 8'h0a, v, ok);
        check(v[15:8], 8'h12);
        check(v[7:0], 8'h34);
        @(posedge ref_clk);
        current <= 16'h1111;
        fork
            u_master.rd(DEV_NEW, 8'h0e, v, ok);
            begin
                #2600;
                @(posedge ref_clk);
                current <= 16'h2222;
            end
        join
        check(v[15:8], 8'h11);
        check(v[7:0], 8'h11);
        $display("done: read-only and latch");
        u_master.wr(DEV_NEW, 8'h01, 8'h20, 8'h00, ok);
        u_master.step(1'b1, 1'b1);
        u_master.step(1'b0, 1'b1);
        repeat (120) @(posedge ref_clk);
        check(sleep_req, 1'b1);
        u_master.step(1'b1, 1'b1);
        u_master.step(1'b1, 1'b0);
        repeat (20) @(posedge ref_clk);
        check(sleep_req, 1'b0);
        $display("done: sleep");
        end_of_test();
    end
endmodule
